// ===== verilog/ebp_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EBP_REGS_SVH
`define EBP_REGS_SVH

// ============================================================
// Register offsets (byte addresses)
`define EBP_OFF_CTRL 8'h4c
`define EBP_OFF_STYLE 8'h50
`define EBP_OFF_ALIAS 8'he8

// ============================================================
// Control/status field positions
`define EBP_BIT_VALID 15
`define EBP_BIT_CMD 14
`define EBP_BIT_DET 13
`define EBP_BIT_EN 4
`define EBP_BIT_RES 3
`define EBP_BIT_CS 2
`define EBP_BIT_SK 1
`define EBP_BIT_DATA 0

// ============================================================
// Software-style field positions
`define EBP_STYLE_MSB 7
`define EBP_STYLE_LSB 0
`define EBP_BIT_SIZE32 8
`define EBP_BIT_OBSOLETE 10

// ============================================================
// Reset values
`define EBP_CTRL_BIT_RST 1'b0
`define EBP_STYLE_RST 8'h00

// ============================================================
// Timing and sequence counts
// Long enough for the driven clock pin to come back through both syncs
`define EBP_DETECT_WAIT 4'hf
`define EBP_READ_OPCODE 3'h6
`define EBP_OPCODE_BITS 3
`define EBP_SHORT_BITS 2

`endif

// ===== verilog/ebp_pkg.sv
// Types shared by the serial-memory port design
package ebp_pkg;

  // ============================================================
  // Sequential read engine states
  typedef enum logic [1:0] {
    EBP_ST_IDLE,
    EBP_ST_RUN,
    EBP_ST_END
  } ebp_eng_state_e;

  typedef logic [7:0] ebp_addr_t;

endpackage

// ===== verilog/ebp_sync.sv
// Three-stage synchroniser with agreement filter on the last two stages
module ebp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  initial begin
    if (W < 1) $error("ebp_sync: W must be at least 1");
  end

  // ============================================================
  // Stages; only the second stage looks at the first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        q[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        q[i] <= s3_r[i];
      end
    end
  end

endmodule // ebp_sync

// ===== verilog/ebp_read_engine.sv
// Sequential read engine driving the serial memory pins on the link clock
`include "ebp_regs.svh"
module ebp_read_engine import ebp_pkg::*; #(
  parameter int ADDR_BITS = 6,
  parameter int WORDS = 64
) (
  // Clock and reset
  input wire logic clk_link,
  input wire logic resetn,
  // Request side (already synchronised)
  input wire logic start_tgl,
  input wire logic short_run,
  output logic done_tgl,
  output logic ok,
  // Pin side
  output logic busy,
  output logic cs,
  output logic sk,
  output logic di
);

  localparam int HDR = `EBP_OPCODE_BITS + ADDR_BITS;
  localparam int BITS = HDR + 16 * WORDS;
  localparam int CW = $clog2(BITS + 1);
  localparam logic [HDR-1:0] HDR_WORD = {`EBP_READ_OPCODE,
                                         {ADDR_BITS{1'b0}}};

  initial begin
    if (ADDR_BITS < 1 || WORDS < 1) $error("ebp_read_engine: bad size");
  end

  ebp_eng_state_e st_r;
  logic start_prev_r;
  logic phase_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] limit;
  logic [CW-1:0] cnt_nxt;

  assign limit = short_run ? CW'(`EBP_SHORT_BITS) : CW'(BITS);
  assign cnt_nxt = cnt_r + 1'b1;

  // Header bits first, then the memory shifts data while we hold zero
  function automatic logic hdr_bit(input logic [CW-1:0] n);
    hdr_bit = 1'b0;
    for (int k = 0; k < HDR; k++) begin
      if (int'(n) == k) hdr_bit = HDR_WORD[HDR-1-k];
    end
  endfunction

  // ============================================================
  // Sequence
  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      st_r <= EBP_ST_IDLE;
      start_prev_r <= 1'b0;
      phase_r <= 1'b0;
      cnt_r <= '0;
      busy <= 1'b0;
      cs <= 1'b0;
      sk <= 1'b0;
      di <= 1'b0;
      ok <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      start_prev_r <= start_tgl;
      case (st_r)
        EBP_ST_IDLE: begin
          if (start_tgl != start_prev_r) begin
            st_r <= EBP_ST_RUN;
            busy <= 1'b1;
            cs <= 1'b1;
            sk <= 1'b0;
            cnt_r <= '0;
            phase_r <= 1'b0;
            di <= hdr_bit('0);
          end
        end
        EBP_ST_RUN: begin
          phase_r <= ~phase_r;
          if (!phase_r) begin
            sk <= 1'b1;
          end else begin
            sk <= 1'b0;
            cnt_r <= cnt_nxt;
            di <= hdr_bit(cnt_nxt);
            if (cnt_nxt == limit) begin
              st_r <= EBP_ST_END;
              cs <= 1'b0;
              ok <= ~short_run;
            end
          end
        end
        EBP_ST_END: begin
          // Ok settles one cycle before the toggle that reports it
          st_r <= EBP_ST_IDLE;
          busy <= 1'b0;
          done_tgl <= ~done_tgl;
        end
        default: begin
          st_r <= EBP_ST_IDLE;
        end
      endcase
    end
  end

endmodule // ebp_read_engine

// ===== verilog/ebp_port_mux.sv
// Serial memory bit-bang port, sequential read control and pin mux
// ============================================================
// Summary of operation
// - Port enable drives select, clock, data pins
// - Disabled and idle: select pin held low
// - Disabled and idle: pins carry indicator outputs
// - Reset tristates clock and data pins, holds select low; read engine owns pins
// - Port enable clears on hardware reset or a control write with bit 4 low
// - Select bit reaches select pin on the fifth link edge after the write
// - Select bit ignored unless enabled and idle
// - Clock bit reaches clock pin on the fifth link edge after the write
// - Data bit drives data pin only when enabled
// - Data bit reads back the data-in pin
// - Select, clock, data bits reset to zero
// - Reserved bit between enable and select reads zero
// - Style register and its alias share storage
// - Obsolete style bit ignores writes, reads zero
// - Reserved style bits read as zero
// - Read command clears valid, runs read, self-clears
`include "ebp_regs.svh"
module ebp_port_mux import ebp_pkg::*; #(
  parameter int ADDR_BITS = 6,
  parameter int WORDS = 64
) (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic resetn,
  // Register port
  input wire ebp_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Indicator outputs from the indicator control logic
  input wire logic indicator_one_output,
  input wire logic indicator_zero_output,
  // Serial memory pins
  output logic eeprom_select_pin,
  output logic eeprom_clock_pin_o,
  output logic eeprom_clock_pin_oe,
  input wire logic eeprom_clock_pin_i,
  output logic eeprom_data_out_pin_o,
  output logic eeprom_data_out_pin_oe,
  input wire logic eeprom_data_in_pin
);

  // ============================================================
  // Declarations
  logic port_enable_bit_r;
  logic select_control_bit_r;
  logic serial_clock_bit_r;
  logic serial_data_bit_r;
  logic reload_command_bit_r;
  logic read_valid_flag_r;
  logic detect_r;
  logic detect_done_r;
  logic [3:0] detect_cnt_r;
  logic auto_go_r;
  logic auto_run_r;
  logic short_r;
  logic start_tgl_r;
  logic done_prev_r;
  logic [7:0] style_r;
  logic size32;
  logic busy_sys;
  logic done_evt;
  logic ctrl_wr;
  logic style_wr;
  logic host_start;
  logic [1:0] pins_s;
  logic [1:0] back_s;
  logic [7:0] fwd_s;
  logic en_l;
  logic cs_l;
  logic sk_l;
  logic di_l;
  logic start_l;
  logic short_l;
  logic indicator_one_output_l;
  logic indicator_zero_output_l;
  logic eng_done_tgl;
  logic eng_ok;
  logic eng_busy;
  logic eng_cs;
  logic eng_sk;
  logic eng_di;
  logic [31:0] rdata_nxt;

  assign ctrl_wr = reg_wr && reg_addr == `EBP_OFF_CTRL;
  // Both locations decode to one storage
  assign style_wr = reg_wr && (reg_addr == `EBP_OFF_STYLE ||
                               reg_addr == `EBP_OFF_ALIAS);
  assign busy_sys = reload_command_bit_r || auto_run_r || auto_go_r ||
                    !detect_done_r;
  assign host_start = ctrl_wr && reg_wdata[`EBP_BIT_CMD] && !busy_sys;
  assign done_evt = back_s[1] != done_prev_r;
  // Reserved style codes report wide structures as well
  assign size32 = style_r != `EBP_STYLE_RST;

  // ============================================================
  // Crossings
  // Pin inputs into the system domain
  ebp_sync #(.W(2)) u_sync_pins (
    .clk(clk_sys),
    .resetn(resetn),
    .d({eeprom_clock_pin_i, eeprom_data_in_pin}),
    .q(pins_s)
  );

  // Engine result back into the system domain
  ebp_sync #(.W(2)) u_sync_back (
    .clk(clk_sys),
    .resetn(resetn),
    .d({eng_done_tgl, eng_ok}),
    .q(back_s)
  );

  // Control levels into the link domain; a write touching clock and
  // data together may reach the pins one link cycle apart
  ebp_sync #(.W(8)) u_sync_fwd (
    .clk(clk_link),
    .resetn(resetn),
    .d({port_enable_bit_r, select_control_bit_r, serial_clock_bit_r,
        serial_data_bit_r, start_tgl_r, short_r, indicator_one_output,
        indicator_zero_output}),
    .q(fwd_s)
  );

  assign {en_l, cs_l, sk_l, di_l, start_l, short_l, indicator_one_output_l, indicator_zero_output_l} = fwd_s;

  // ============================================================
  // Bit-bang control bits
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      port_enable_bit_r <= `EBP_CTRL_BIT_RST;
      select_control_bit_r <= `EBP_CTRL_BIT_RST;
      serial_clock_bit_r <= `EBP_CTRL_BIT_RST;
      serial_data_bit_r <= `EBP_CTRL_BIT_RST;
    end else if (ctrl_wr) begin
      port_enable_bit_r <= reg_wdata[`EBP_BIT_EN];
      select_control_bit_r <= reg_wdata[`EBP_BIT_CS];
      serial_clock_bit_r <= reg_wdata[`EBP_BIT_SK];
      serial_data_bit_r <= reg_wdata[`EBP_BIT_DATA];
    end
  end

  // ============================================================
  // Memory detect after reset
  // The clock pin floats while reset holds, so it is read afterwards;
  // the wait covers the trip out through the pin flop and back in
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      detect_cnt_r <= '0;
      detect_done_r <= 1'b0;
      detect_r <= 1'b0;
    end else if (!detect_done_r) begin
      detect_cnt_r <= detect_cnt_r + 1'b1;
      if (detect_cnt_r == `EBP_DETECT_WAIT) begin
        detect_done_r <= 1'b1;
        detect_r <= pins_s[1];
      end
    end
  end

  // ============================================================
  // Read sequence control
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reload_command_bit_r <= 1'b0;
      read_valid_flag_r <= 1'b0;
      auto_go_r <= 1'b0;
      auto_run_r <= 1'b0;
      short_r <= 1'b0;
      start_tgl_r <= 1'b0;
      done_prev_r <= 1'b0;
    end else begin
      done_prev_r <= back_s[1];
      if (!detect_done_r && detect_cnt_r == `EBP_DETECT_WAIT) begin
        // No memory seen: only a short clock burst, then give up
        auto_go_r <= 1'b1;
        short_r <= !pins_s[1];
      end else if (auto_go_r) begin
        auto_go_r <= 1'b0;
        auto_run_r <= 1'b1;
        start_tgl_r <= ~start_tgl_r;
      end else if (host_start) begin
        reload_command_bit_r <= 1'b1;
        read_valid_flag_r <= 1'b0;
        start_tgl_r <= ~start_tgl_r;
      end else if (done_evt) begin
        reload_command_bit_r <= 1'b0;
        auto_run_r <= 1'b0;
        short_r <= 1'b0;
        read_valid_flag_r <= back_s[0];
      end
    end
  end

  // ============================================================
  // Software style storage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      style_r <= `EBP_STYLE_RST;
    end else if (style_wr) begin
      style_r <= reg_wdata[`EBP_STYLE_MSB:`EBP_STYLE_LSB];
    end
  end

  // ============================================================
  // Read data
  always_comb begin
    rdata_nxt = '0;
    if (reg_addr == `EBP_OFF_CTRL) begin
      rdata_nxt[`EBP_BIT_VALID] = read_valid_flag_r;
      rdata_nxt[`EBP_BIT_CMD] = reload_command_bit_r;
      rdata_nxt[`EBP_BIT_DET] = detect_r;
      rdata_nxt[`EBP_BIT_EN] = port_enable_bit_r;
      rdata_nxt[`EBP_BIT_RES] = 1'b0;
      rdata_nxt[`EBP_BIT_CS] = select_control_bit_r;
      rdata_nxt[`EBP_BIT_SK] = serial_clock_bit_r;
      rdata_nxt[`EBP_BIT_DATA] = pins_s[0];
    end else if (reg_addr == `EBP_OFF_STYLE ||
                 reg_addr == `EBP_OFF_ALIAS) begin
      rdata_nxt[`EBP_STYLE_MSB:`EBP_STYLE_LSB] = style_r;
      rdata_nxt[`EBP_BIT_SIZE32] = size32;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ============================================================
  // Read engine on the link clock
  ebp_read_engine #(.ADDR_BITS(ADDR_BITS), .WORDS(WORDS)) u_engine (
    .clk_link(clk_link),
    .resetn(resetn),
    .start_tgl(start_l),
    .short_run(short_l),
    .done_tgl(eng_done_tgl),
    .ok(eng_ok),
    .busy(eng_busy),
    .cs(eng_cs),
    .sk(eng_sk),
    .di(eng_di)
  );

  // ============================================================
  // Pin ownership: reset, then read engine, then bit-bang, then LEDs
  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      eeprom_select_pin <= 1'b0;
      eeprom_clock_pin_o <= 1'b0;
      eeprom_clock_pin_oe <= 1'b0;
      eeprom_data_out_pin_o <= 1'b0;
      eeprom_data_out_pin_oe <= 1'b0;
    end else begin
      eeprom_clock_pin_oe <= 1'b1;
      eeprom_data_out_pin_oe <= 1'b1;
      if (eng_busy) begin
        eeprom_select_pin <= eng_cs;
        eeprom_clock_pin_o <= eng_sk;
        eeprom_data_out_pin_o <= eng_di;
      end else if (en_l) begin
        eeprom_select_pin <= cs_l;
        eeprom_clock_pin_o <= sk_l;
        eeprom_data_out_pin_o <= di_l;
      end else begin
        eeprom_select_pin <= 1'b0;
        eeprom_clock_pin_o <= indicator_one_output_l;
        eeprom_data_out_pin_o <= indicator_zero_output_l;
      end
    end
  end

  // ============================================================
  // Checks in the link domain
  property p_select_bitbang;
    @(posedge clk_link) disable iff (!resetn)
    en_l && !eng_busy |=> eeprom_select_pin == $past(cs_l);
  endproperty
  a_select_bitbang: assert property (p_select_bitbang)
    else $error("select pin does not follow select bit");

  property p_clock_bitbang;
    @(posedge clk_link) disable iff (!resetn)
    en_l && !eng_busy |=> eeprom_clock_pin_o == $past(sk_l) &&
                          eeprom_clock_pin_oe;
  endproperty
  a_clock_bitbang: assert property (p_clock_bitbang)
    else $error("clock pin does not follow clock bit");

  property p_data_bitbang;
    @(posedge clk_link) disable iff (!resetn)
    en_l && !eng_busy |=> eeprom_data_out_pin_o == $past(di_l);
  endproperty
  a_data_bitbang: assert property (p_data_bitbang)
    else $error("data pin does not follow data bit");

  property p_idle_select_low;
    @(posedge clk_link) disable iff (!resetn)
    !en_l && !eng_busy |=> !eeprom_select_pin;
  endproperty
  a_idle_select_low: assert property (p_idle_select_low)
    else $error("select pin high while port idle");

  property p_idle_leds;
    @(posedge clk_link) disable iff (!resetn)
    !en_l && !eng_busy |=> eeprom_clock_pin_o == $past(indicator_one_output_l) &&
                           eeprom_data_out_pin_o == $past(indicator_zero_output_l);
  endproperty
  a_idle_leds: assert property (p_idle_leds)
    else $error("indicator outputs not on idle pins");

  property p_engine_owns;
    @(posedge clk_link) disable iff (!resetn)
    eng_busy |=> eeprom_select_pin == $past(eng_cs) &&
                 eeprom_clock_pin_o == $past(eng_sk);
  endproperty
  a_engine_owns: assert property (p_engine_owns)
    else $error("read engine lost the pins");

  // ============================================================
  // Checks in the system domain
  property p_cmd_clears_valid;
    @(posedge clk_sys) disable iff (!resetn)
    host_start |=> reload_command_bit_r && !read_valid_flag_r;
  endproperty
  a_cmd_clears_valid: assert property (p_cmd_clears_valid)
    else $error("read command did not clear valid");

  property p_cmd_self_clear;
    @(posedge clk_sys) disable iff (!resetn)
    reload_command_bit_r && done_evt |=>
      !reload_command_bit_r && read_valid_flag_r == $past(back_s[0]);
  endproperty
  a_cmd_self_clear: assert property (p_cmd_self_clear)
    else $error("read command did not end cleanly");

  property p_enable_holds;
    @(posedge clk_sys) disable iff (!resetn)
    !ctrl_wr |=> $stable(port_enable_bit_r);
  endproperty
  a_enable_holds: assert property (p_enable_holds)
    else $error("port enable changed without a write");

  property p_ctrl_readback;
    @(posedge clk_sys) disable iff (!resetn)
    reg_rd && reg_addr == `EBP_OFF_CTRL |=>
      reg_rdata[`EBP_BIT_CS] == $past(select_control_bit_r) &&
      reg_rdata[`EBP_BIT_SK] == $past(serial_clock_bit_r) &&
      reg_rdata[`EBP_BIT_DATA] == $past(pins_s[0]) &&
      !reg_rdata[`EBP_BIT_RES];
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("control readback wrong");

  property p_alias_shared;
    @(posedge clk_sys) disable iff (!resetn)
    style_wr ##1 !style_wr ##1 reg_rd && reg_addr == `EBP_OFF_ALIAS |=>
      reg_rdata[`EBP_STYLE_MSB:`EBP_STYLE_LSB] ==
      $past(reg_wdata[`EBP_STYLE_MSB:`EBP_STYLE_LSB], 3);
  endproperty
  a_alias_shared: assert property (p_alias_shared)
    else $error("style alias does not share storage");

  property p_style_reserved;
    @(posedge clk_sys) disable iff (!resetn)
    reg_rd && reg_addr == `EBP_OFF_STYLE |=>
      reg_rdata[31:9] == 23'h000000;
  endproperty
  a_style_reserved: assert property (p_style_reserved)
    else $error("style reserved or obsolete bits not zero");

endmodule // ebp_port_mux

// ===== dv/ebp_mem_model.sv
// Behavioural serial memory that answers sequential reads
module ebp_mem_model #(
  parameter int HDR = 9
) (
  // Pins as the memory sees them
  input wire logic sel,
  input wire logic sck,
  input wire logic din,
  output logic dout,
  // Bench visibility
  output int rises
);
  timeunit 1ns;
  timeprecision 1ps;
  int bits;
  logic [15:0] word;

  // ============================================================
  // Clock and bit counting
  initial begin
    bits = 0;
    rises = 0;
    word = 16'h0000;
    dout = 1'b1;
  end

  always @(posedge sck) begin
    rises++;
    if (sel) begin
      bits++;
    end
  end

  always @(posedge sel) begin
    bits = 0;
  end

  // ============================================================
  // Data out: the address auto-increments every 16 bits
  always @(negedge sck) begin
    if (sel && bits >= HDR) begin
      dout = word[15 - ((bits - HDR) % 16)];
      if ((bits - HDR) % 16 == 15) begin
        word = word + 16'h0001;
      end
    end
  end

  // Released line has no pull: show the inverse so stale data never passes
  always @(negedge sel) begin
    dout = ~dout;
  end
endmodule // ebp_mem_model

// ===== dv/eeprom_bitbang_port_mux_tb.sv
// Self-checking bench for the serial memory port and pin mux
`include "ebp_regs.svh"
module eeprom_bitbang_port_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ebp_pkg::*;
  localparam int AB = 6;
  localparam int WD = 2;
  localparam int FULL = `EBP_OPCODE_BITS + AB + 16 * WD;
  typedef struct {
    logic [31:0] w;
    logic i1;
    logic i0;
    logic [2:0] pins;
  } ebp_row_s;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic resetn, reg_wr, reg_rd, ind1, ind0;
  ebp_addr_t reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic sel, clk_o, clk_oe, dat_o, dat_oe, din, clk_w, dat_w;
  int fails = 0;
  int compares = 0;
  int n0;
  ebp_row_s rows[6];

  // ============================================================
  // Clocks, pins and instances
  always #5 clk_sys = ~clk_sys;
  always begin
    #3.7;
    forever #6 clk_link = ~clk_link;
  end
  // Indicator line carries a pull-up, so tri-state reads high
  assign clk_w = clk_oe ? clk_o : 1'b1;
  assign dat_w = dat_oe ? dat_o : 1'b1;

  ebp_port_mux #(.ADDR_BITS(AB), .WORDS(WD)) DUT (
    .clk_sys(clk_sys), .clk_link(clk_link), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .indicator_one_output(ind1), .indicator_zero_output(ind0),
    .eeprom_select_pin(sel), .eeprom_clock_pin_o(clk_o),
    .eeprom_clock_pin_oe(clk_oe), .eeprom_clock_pin_i(clk_w),
    .eeprom_data_out_pin_o(dat_o), .eeprom_data_out_pin_oe(dat_oe),
    .eeprom_data_in_pin(din));

  ebp_mem_model #(.HDR(`EBP_OPCODE_BITS + AB)) mem (
    .sel(sel), .sck(clk_w), .din(dat_w), .dout(din), .rises());

  // ============================================================
  // Bus tasks and checking
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input ebp_addr_t a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input ebp_addr_t a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Poll until valid and command bits reach the wanted pair, bounded
  task automatic poll(input logic [1:0] want);
    int n;
    n = 0;
    reg_read(`EBP_OFF_CTRL, d);
    while (d[15:14] !== want && n < 400) begin
      reg_read(`EBP_OFF_CTRL, d);
      n++;
    end
    check({30'h0, d[15:14]}, {30'h0, want});
  endtask

  task automatic give_verdict;
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ============================================================
  // Watchdog sized well above the longest run
  initial begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  // ============================================================
  // Main sequence
  initial begin
    rows = '{'{32'h14, 1'b0, 1'b0, 3'b100}, '{32'h16, 1'b0, 1'b0, 3'b110},
             '{32'h17, 1'b0, 1'b0, 3'b111}, '{32'h13, 1'b0, 1'b0, 3'b011},
             '{32'h07, 1'b0, 1'b1, 3'b001}, '{32'h06, 1'b1, 1'b0, 3'b010}};
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ind1 = 1'b1;
    ind0 = 1'b0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    // Memory detected through the pulled-up indicator: full auto read
    poll(2'b10);
    check({31'h0, d[13]}, 32'h1);
    // No row changes both clock and data
    foreach (rows[i]) begin
      @(posedge clk_sys);
      ind1 <= rows[i].i1;
      ind0 <= rows[i].i0;
      reg_write(`EBP_OFF_CTRL, rows[i].w);
      repeat (15) @(posedge clk_link);
      check({29'h0, sel, clk_w, dat_w}, {29'h0, rows[i].pins});
      reg_read(`EBP_OFF_CTRL, d);
      check({28'h0, d[4:1]},
            {28'h0, rows[i].w[4], 1'b0, rows[i].w[2:1]});
      check({31'h0, d[0]}, {31'h0, din});
    end
    // Style register and its alias
    reg_write(`EBP_OFF_STYLE, 32'hffff_ffff);
    reg_read(`EBP_OFF_ALIAS, d);
    check(d, 32'h0000_01ff);
    reg_write(`EBP_OFF_ALIAS, 32'h0000_0002);
    reg_read(`EBP_OFF_STYLE, d);
    check(d, 32'h0000_0102);
    reg_write(`EBP_OFF_STYLE, 32'h0);
    reg_read(`EBP_OFF_ALIAS, d);
    check(d, 32'h0);
    reg_read(8'h10, d);
    check(d, 32'h0);
    @(posedge clk_sys);
    #1;
    check(reg_rdata, 32'h0);
    // Host read with bit-bang enabled and select bit low
    reg_write(`EBP_OFF_CTRL, 32'h10);
    repeat (15) @(posedge clk_link);
    n0 = mem.rises;
    reg_write(`EBP_OFF_CTRL, 32'h4010);
    reg_read(`EBP_OFF_CTRL, d);
    check({30'h0, d[15:14]}, 32'h1);
    for (int n = 0; n < 100 && sel !== 1'b1; n++) @(posedge clk_link);
    check({31'h0, sel}, 32'h1);
    poll(2'b10);
    check(mem.rises - n0, FULL);
    // Reset after the host read completes, with no memory detected: short read only
    @(posedge clk_sys);
    ind1 <= 1'b0;
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({29'h0, sel, clk_oe, dat_oe}, 32'h0);
    n0 = mem.rises;
    repeat (7) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (80) @(posedge clk_sys);
    poll(2'b00);
    check(mem.rises - n0, 2);
    check({28'h0, d[13], d[4], d[2:1]}, 32'h0);
    check({31'h0, d[0]}, {31'h0, din});
    give_verdict();
  end
endmodule // eeprom_bitbang_port_mux_tb
